//--- hdl/slc_regs.vh
// offsets, field positions, reset values and encodings of the serial link control registers
`ifndef SLC_REGS_VH
`define SLC_REGS_VH

`define SLC_OFF_LINK_ENABLE    12'h200
`define SLC_OFF_OUTPUT_MODE    12'h201
`define SLC_OFF_MULTIFRAME     12'h202
`define SLC_OFF_MANUAL_SYNC    12'h203
`define SLC_OFF_LINK_CONTROL   12'h204
`define SLC_OFF_TEST_PATTERN   12'h205
`define SLC_OFF_DEVICE_IDENT   12'h206
`define SLC_OFF_FRAME_CHAR     12'h207
`define SLC_OFF_STATUS         12'h208
`define SLC_OFF_POWERDOWN      12'h209
`define SLC_OFF_EXTRA_A        12'h20A
`define SLC_OFF_EXTRA_B        12'h20B
`define SLC_OFF_CAL_ENABLE     12'h210

`define SLC_RST_LINK_ENABLE    8'h01
`define SLC_RST_OUTPUT_MODE    8'h02
`define SLC_RST_MULTIFRAME     8'h1F
`define SLC_RST_MANUAL_SYNC    8'h01
`define SLC_RST_LINK_CONTROL   8'h02
`define SLC_RST_ZERO           8'h00

`define SLC_MODE_WIDTH         5
`define SLC_SYNC_SEL_LSB       2
`define SLC_SYNC_SEL_MSB       3
`define SLC_SYNC_SE            2'h0
`define SLC_SYNC_DIFFERENTIAL_TIMESTAMP_INPUT         2'h1
`define SLC_SYNC_NONE          2'h2

`endif

//--- hdl/slc_sync_select.v
// synchronisation request combiner: hardware source select plus software request
`timescale 1ns/1ps
module slc_sync_select (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [1:0] sync_sel,
   input  wire       manual_sync_request_n,
   input  wire       single_ended_sync_input_n,
   input  wire       differential_timestamp_input_n,
   input  wire       timestamp_receiver_enable,
   output reg        sync_request
);
`include "slc_regs.vh"

   reg hw_request;

   always @* begin
      hw_request = 1'b0;
      case (sync_sel)
         `SLC_SYNC_SE:    hw_request = ~single_ended_sync_input_n;
         `SLC_SYNC_DIFFERENTIAL_TIMESTAMP_INPUT: hw_request = timestamp_receiver_enable & ~differential_timestamp_input_n;
         default:         hw_request = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_request <= 1'b0;
      end else begin
         sync_request <= hw_request | ~manual_sync_request_n;
      end
   end
endmodule // slc_sync_select

//--- hdl/slc_link_regs.v
// serial link control register bank with apb slave
`timescale 1ns/1ps
module slc_link_regs (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        single_ended_sync_input_n,
   input  wire        differential_timestamp_input_n,
   input  wire        timestamp_receiver_enable,
   input  wire [7:0]  link_system_status,
   output reg         link_reset_n,
   output reg         serializer_power_on,
   output reg         link_clock_enable,
   output reg         lmfc_reset_n,
   output reg         calibration_enable,
   output reg  [4:0]  output_mode_select,
   output reg  [4:0]  frames_per_multiframe_minus_one,
   output reg  [7:0]  link_control,
   output reg  [3:0]  test_pattern_select,
   output reg  [7:0]  device_ident,
   output reg  [1:0]  end_of_frame_char_select,
   output reg  [7:0]  channel_powerdown,
   output reg  [7:0]  extra_lane_enable_a,
   output reg  [7:0]  extra_lane_enable_b,
   output wire        sync_request
);
`include "slc_regs.vh"

   reg  [7:0] link_enable_reg;
   reg  [7:0] output_mode_reg;
   reg  [7:0] multiframe_length_reg;
   reg  [7:0] manual_sync_request_reg;
   reg  [7:0] link_control_reg;
   reg  [7:0] test_pattern_reg;
   reg  [7:0] device_ident_param_reg;
   reg  [7:0] end_of_frame_char_reg;
   reg  [7:0] channel_powerdown_reg;
   reg  [7:0] extra_lane_enable_a_reg;
   reg  [7:0] extra_lane_enable_b_reg;
   reg  [7:0] cal_enable_reg;
   reg  [7:0] next_rdata;
   reg        next_err;
   wire       access;
   wire       wr;

   assign access = psel & penable & ~pready;
   assign wr     = access & pwrite & pstrb[0];

   // byte update honouring the lowest byte lane only
   function [7:0] wbyte;
      input [7:0] old;
      input [7:0] data;
      begin
         wbyte = data;
      end
   endfunction

   // offsets are register indices; the byte address is four times the index
   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr[1:0] == 2'b00) && (addr[11:2] == off[9:0]);
      end
   endfunction

   // read decode and unmapped detect
   always @* begin
      next_rdata = 8'h00;
      next_err   = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         next_err = 1'b1;
      end else if (hit(paddr, `SLC_OFF_LINK_ENABLE)) begin
         next_rdata = link_enable_reg;
      end else if (hit(paddr, `SLC_OFF_OUTPUT_MODE)) begin
         next_rdata = output_mode_reg;
      end else if (hit(paddr, `SLC_OFF_MULTIFRAME)) begin
         next_rdata = multiframe_length_reg;
      end else if (hit(paddr, `SLC_OFF_MANUAL_SYNC)) begin
         next_rdata = manual_sync_request_reg;
      end else if (hit(paddr, `SLC_OFF_LINK_CONTROL)) begin
         next_rdata = link_control_reg;
      end else if (hit(paddr, `SLC_OFF_TEST_PATTERN)) begin
         next_rdata = test_pattern_reg;
      end else if (hit(paddr, `SLC_OFF_DEVICE_IDENT)) begin
         next_rdata = device_ident_param_reg;
      end else if (hit(paddr, `SLC_OFF_FRAME_CHAR)) begin
         next_rdata = end_of_frame_char_reg;
      end else if (hit(paddr, `SLC_OFF_STATUS)) begin
         next_rdata = link_system_status;
      end else if (hit(paddr, `SLC_OFF_POWERDOWN)) begin
         next_rdata = channel_powerdown_reg;
      end else if (hit(paddr, `SLC_OFF_EXTRA_A)) begin
         next_rdata = extra_lane_enable_a_reg;
      end else if (hit(paddr, `SLC_OFF_EXTRA_B)) begin
         next_rdata = extra_lane_enable_b_reg;
      end else if (hit(paddr, `SLC_OFF_CAL_ENABLE)) begin
         next_rdata = cal_enable_reg;
      end else begin
         next_err = 1'b1;
      end
   end

   // apb answer one cycle into the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= access;
         pslverr <= access & next_err;
         if (access && !pwrite) begin
            prdata <= {24'h000000, next_rdata};
         end
      end
   end

   // register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_enable_reg         <= `SLC_RST_LINK_ENABLE;
         output_mode_reg         <= `SLC_RST_OUTPUT_MODE;
         multiframe_length_reg   <= `SLC_RST_MULTIFRAME;
         manual_sync_request_reg <= `SLC_RST_MANUAL_SYNC;
         link_control_reg        <= `SLC_RST_LINK_CONTROL;
         test_pattern_reg        <= `SLC_RST_ZERO;
         device_ident_param_reg  <= `SLC_RST_ZERO;
         end_of_frame_char_reg   <= `SLC_RST_ZERO;
         channel_powerdown_reg   <= `SLC_RST_ZERO;
         extra_lane_enable_a_reg <= `SLC_RST_ZERO;
         extra_lane_enable_b_reg <= `SLC_RST_ZERO;
         cal_enable_reg          <= `SLC_RST_ZERO;
      end else if (wr && !next_err) begin
         if (hit(paddr, `SLC_OFF_LINK_ENABLE)) begin
            link_enable_reg <= wbyte(link_enable_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_OUTPUT_MODE)) begin
            output_mode_reg <= wbyte(output_mode_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_MULTIFRAME)) begin
            multiframe_length_reg <= wbyte(multiframe_length_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_MANUAL_SYNC)) begin
            manual_sync_request_reg <= wbyte(manual_sync_request_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_LINK_CONTROL)) begin
            link_control_reg <= wbyte(link_control_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_TEST_PATTERN)) begin
            test_pattern_reg <= wbyte(test_pattern_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_DEVICE_IDENT)) begin
            device_ident_param_reg <= {pwdata[7:1], 1'b0};
         end else if (hit(paddr, `SLC_OFF_FRAME_CHAR)) begin
            end_of_frame_char_reg <= wbyte(end_of_frame_char_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_POWERDOWN)) begin
            channel_powerdown_reg <= wbyte(channel_powerdown_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_EXTRA_A)) begin
            extra_lane_enable_a_reg <= wbyte(extra_lane_enable_a_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_EXTRA_B)) begin
            extra_lane_enable_b_reg <= wbyte(extra_lane_enable_b_reg, pwdata[7:0]);
         end else if (hit(paddr, `SLC_OFF_CAL_ENABLE)) begin
            cal_enable_reg <= {7'h00, pwdata[0]};
         end
      end
   end

   // link side effects and configuration outputs, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_reset_n                    <= 1'b0;
         serializer_power_on             <= 1'b0;
         link_clock_enable               <= 1'b0;
         lmfc_reset_n                    <= 1'b0;
         calibration_enable              <= 1'b0;
         output_mode_select              <= 5'h02;
         frames_per_multiframe_minus_one <= 5'h1F;
         link_control                    <= `SLC_RST_LINK_CONTROL;
         test_pattern_select             <= 4'h0;
         device_ident                    <= 8'h00;
         end_of_frame_char_select        <= 2'h0;
         channel_powerdown               <= 8'h00;
         extra_lane_enable_a             <= 8'h00;
         extra_lane_enable_b             <= 8'h00;
      end else begin
         link_reset_n                    <= link_enable_reg[0];
         serializer_power_on             <= link_enable_reg[0];
         link_clock_enable               <= link_enable_reg[0];
         lmfc_reset_n                    <= link_enable_reg[0];
         calibration_enable              <= cal_enable_reg[0];
         output_mode_select              <= output_mode_reg[4:0];
         frames_per_multiframe_minus_one <= multiframe_length_reg[4:0];
         link_control                    <= link_control_reg;
         test_pattern_select             <= test_pattern_reg[3:0];
         device_ident                    <= device_ident_param_reg;
         end_of_frame_char_select        <= end_of_frame_char_reg[1:0];
         channel_powerdown               <= channel_powerdown_reg;
         extra_lane_enable_a             <= extra_lane_enable_a_reg;
         extra_lane_enable_b             <= extra_lane_enable_b_reg;
      end
   end

   slc_sync_select u_sync (
      .pclk                           (pclk),
      .presetn                        (presetn),
      .sync_sel                       (link_control_reg[`SLC_SYNC_SEL_MSB:`SLC_SYNC_SEL_LSB]),
      .manual_sync_request_n          (manual_sync_request_reg[0]),
      .single_ended_sync_input_n      (single_ended_sync_input_n),
      .differential_timestamp_input_n (differential_timestamp_input_n),
      .timestamp_receiver_enable      (timestamp_receiver_enable),
      .sync_request                   (sync_request)
   );
endmodule // slc_link_regs

//--- testbench/slc_link_regs_assertions.sv
// concurrent checks on the serial link control register bank ports
`timescale 1ns/1ps
module slc_link_regs_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        single_ended_sync_input_n,
   input wire logic [7:0]  link_control,
   input wire logic        link_reset_n,
   input wire logic        serializer_power_on,
   input wire logic        link_clock_enable,
   input wire logic        lmfc_reset_n,
   input wire logic        sync_request
);
   // byte address is four times the register index
   localparam logic [11:0] EN_ADDR = 12'h800;
   wire acc = psel && penable && !pready;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   answer_time_a: assert property (acc |=> pready) else $error("no ready after access edge");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   bad_align_a: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr) else $error("unaligned access not refused");
   read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
   enable_write_a: assert property (pready && psel && pwrite && !pslverr && paddr == EN_ADDR && pstrb[0]
      |-> ##2 link_reset_n == $past(pwdata[0], 2)) else $error("link enable write not applied");
   power_tie_a: assert property (!link_reset_n |-> !serializer_power_on) else $error("serializers on while off");
   clock_gate_a: assert property (!link_reset_n |-> !link_clock_enable) else $error("clock on while off");
   lmfc_hold_a: assert property (!link_reset_n |-> !lmfc_reset_n) else $error("lmfc free while off");
   hw_sync_a: assert property (!single_ended_sync_input_n ##1 link_control[3:2] == 2'h0 |-> sync_request)
      else $error("selected sync input ignored");
endmodule // slc_link_regs_assertions

bind slc_link_regs slc_link_regs_assertions i_slc_link_regs_assertions (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .single_ended_sync_input_n, .link_control, .link_reset_n,
   .serializer_power_on, .link_clock_enable, .lmfc_reset_n, .sync_request);

//--- testbench/slc_link_regs_bench.sv
// self-checking bench for the serial link control register bank
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end
module slc_link_regs_bench;
   typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] e; logic err;} slc_row_t;
   logic        pclk, presetn, psel, penable, pwrite, se_n, pready, pslverr, er, sync_request;
   logic        link_reset_n, serializer_power_on, link_clock_enable, lmfc_reset_n, calibration_enable;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [4:0]  mode, frames;
   logic [7:0]  link_control;
   int          n_mismatch = 0, total_checks = 0;
   logic [7:0]  rstv [12] = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00};
   slc_row_t    rows [9] = '{'{12'h800, 8'h00, 8'h00, 1'b0}, '{12'h840, 8'h01, 8'h01, 1'b0},
      '{12'h804, 8'h13, 8'h13, 1'b0}, '{12'h808, 8'h0F, 8'h0F, 1'b0}, '{12'h818, 8'h25, 8'h24, 1'b0},
      '{12'h810, 8'h0A, 8'h0A, 1'b0}, '{12'h80C, 8'h00, 8'h00, 1'b0}, '{12'h830, 8'h55, 8'h00, 1'b1},
      '{12'h802, 8'h00, 8'h00, 1'b1}};
   slc_link_regs i_slc_link_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .single_ended_sync_input_n(se_n), .differential_timestamp_input_n(1'b1), .timestamp_receiver_enable(1'b0),
      .link_system_status(8'h5A), .link_reset_n(link_reset_n), .serializer_power_on(serializer_power_on),
      .link_clock_enable(link_clock_enable), .lmfc_reset_n(lmfc_reset_n), .calibration_enable(calibration_enable),
      .output_mode_select(mode), .frames_per_multiframe_minus_one(frames), .link_control(link_control),
      .test_pattern_select(), .device_ident(), .end_of_frame_char_select(), .channel_powerdown(),
      .extra_lane_enable_a(), .extra_lane_enable_b(), .sync_request(sync_request));
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int i;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge pclk);
      #1;
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      se_n = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      `CHK(link_reset_n, 1'b1);
      for (int i = 0; i < 12; i++) begin
         apb(1'b0, 12'h800 + 12'(4 * i), 8'h00);
         `CHK(rd[7:0], rstv[i]);
      end
      $display("test reset values done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 8'h00);
         `CHK(er, rows[i].err);
         if (!rows[i].err) `CHK(rd[7:0], rows[i].e);
      end
      settle();
      `CHK({link_reset_n, serializer_power_on, link_clock_enable, lmfc_reset_n}, 4'h0);
      `CHK({mode, frames}, {5'h13, 5'h0F});
      `CHK(sync_request, 1'b1);
      $display("test register rows done");
      @(posedge pclk);
      se_n <= 1'b0;
      apb(1'b1, 12'h80C, 8'h01);
      settle();
      `CHK(sync_request, 1'b0);
      apb(1'b1, 12'h810, 8'h02);
      settle();
      `CHK(sync_request, 1'b1);
      @(posedge pclk);
      se_n <= 1'b1;
      settle();
      `CHK(sync_request, 1'b0);
      apb(1'b1, 12'h80C, 8'h00);
      settle();
      `CHK(sync_request, 1'b1);
      apb(1'b1, 12'h80C, 8'h01);
      $display("test sync sources done");
      apb(1'b1, 12'h800, 8'h01);
      settle();
      `CHK(calibration_enable, 1'b1);
      `CHK({link_reset_n, serializer_power_on, link_clock_enable, lmfc_reset_n}, 4'hF);
      apb(1'b1, 12'h800, 8'h00);
      apb(1'b1, 12'h840, 8'h00);
      settle();
      `CHK({link_reset_n, calibration_enable}, 2'b00);
      @(posedge pclk);
      presetn <= 1'b0;
      settle();
      `CHK(link_reset_n, 1'b0);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h808, 8'h00);
      `CHK(rd[7:0], 8'h1F);
      $display("test enable and reset done");
      close_out();
   end
endmodule // slc_link_regs_bench
